// *** hw/qsr_map.vh ***
// constants and register map of the queue status report port
`ifndef QSR_MAP_VH
`define QSR_MAP_VH

// status opcodes
`define QSR_OP_COMPLETION 8'h00
`define QSR_OP_WIDTH 8

// status word layout
`define QSR_FAULT_LSB 0
`define QSR_FAULT_MSB 1
`define QSR_RETRY_BIT 2
`define QSR_COOKIE_LSB 3
`define QSR_COOKIE_MSB 25
`define QSR_COOKIE_W 23
`define QSR_ORIGIN_BIT 26
`define QSR_RSVD_LSB 27
`define QSR_RSVD_MSB 63
`define QSR_RSVD_W 37

// register offsets
`define QSR_REG_CTRL 8'h00
`define QSR_REG_IRQ_STATUS 8'h04
`define QSR_REG_IRQ_MASK 8'h08
`define QSR_REG_STATE 8'h0c
`define QSR_REG_LAST 8'h10

// control fields and reset value
`define QSR_CTRL_ENABLE_BIT 0
`define QSR_CTRL_ERR_EN_BIT 1
`define QSR_CTRL_RESET 2'h3

// interrupt status bits
`define QSR_EV_MARKER 0
`define QSR_EV_ERROR 1
`define QSR_EV_RETRY 2
`define QSR_EV_DROP 3
`define QSR_EV_W 4

// state register fields
`define QSR_STATE_OUT_BIT 0
`define QSR_STATE_HOLD_BIT 1
`define QSR_STATE_DROP_LSB 16

`endif

// *** hw/qsr_flag_mem.v ***
// per-queue interrupt-outstanding flags with registered read
`timescale 1ns/1ps
module qsr_flag_mem #(
    parameter DEPTH = 4096,
    parameter AW = 12
) (
    input wire i_clk, // core clock
    input wire i_rst, // async reset, active high
    input wire [AW-1:0] i_rd_idx, // read index
    output reg o_rd_data, // flag read, one cycle later
    input wire i_set_we, // set a flag
    input wire [AW-1:0] i_set_idx, // index to set
    input wire i_clr_we, // clear a flag
    input wire [AW-1:0] i_clr_idx // index to clear
);

    reg flag_q [0:DEPTH-1];
    integer k;

    // set wins over a clear of the same index
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (k = 0; k < DEPTH; k = k + 1) begin
                flag_q[k] <= 1'b0;
            end
            o_rd_data <= 1'b0;
        end else begin
            if (i_clr_we) begin
                flag_q[i_clr_idx] <= 1'b0;
            end
            if (i_set_we) begin
                flag_q[i_set_idx] <= 1'b1;
            end
            o_rd_data <= flag_q[i_rd_idx];
        end
    end

endmodule

// *** hw/qsr_top.v ***
// queue status report port: marker and error reports to user logic
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "qsr_map.vh"
module qsr_top #(
    parameter QID_W = 12,
    parameter PORT_W = 3,
    parameter ENTRY_W = 32,
    parameter QUEUES = 4096,
    parameter DROP_W = 16
) (
    input wire I_CORE_CLK, // core clock, 20 MHz
    input wire I_RST, // async reset, active high
    // marker responses from the completion engine
    input wire I_MRK_VLD, // marker response event, one cycle
    input wire [1:0] I_MRK_KIND, // marker kind, becomes the opcode
    input wire [1:0] I_MRK_FAULT, // fault code seen with the marker
    input wire I_MRK_IRQ_WANT, // marker asked for an enabled interrupt
    input wire [ENTRY_W-1:0] I_MRK_ENTRY, // completion entry from user logic
    input wire [QID_W-1:0] I_MRK_QID, // queue of the marker
    input wire [PORT_W-1:0] I_MRK_PORT, // port of the marker
    // errors found by the completion engine
    input wire I_ERR_VLD, // error event, one cycle
    input wire [1:0] I_ERR_FAULT, // fault code
    input wire [QID_W-1:0] I_ERR_QID, // queue of the error
    input wire [PORT_W-1:0] I_ERR_PORT, // port of the error
    // interrupt completion on a queue
    input wire I_IRQ_DONE_VLD, // outstanding interrupt finished
    input wire [QID_W-1:0] I_IRQ_DONE_QID, // its queue
    // status output to user logic
    output reg O_STS_VLD, // status valid
    output reg [`QSR_OP_WIDTH-1:0] O_STS_OPCODE, // status opcode
    output reg [63:0] O_STS_DATA, // status word
    output reg [PORT_W-1:0] O_STS_PORT_IDENT, // port identifier
    output reg [QID_W-1:0] O_STS_QID, // queue identifier
    input wire I_STS_RDY, // status ready
    // register port
    input wire [7:0] I_ADDR, // byte address
    input wire [31:0] I_WDATA, // write data
    input wire I_WR, // write strobe
    input wire I_RD, // read strobe
    output reg [31:0] O_RDATA, // read data, cycle after strobe
    output reg O_IRQ // level interrupt
);

    // status word builder, reserved bits zero
    function [63:0] build_word;
        input [1:0] fault;
        input retry;
        input [`QSR_COOKIE_W-1:0] cookie;
        input origin;
        begin
            build_word = {{`QSR_RSVD_W{1'b0}}, origin, cookie, retry, fault};
        end
    endfunction

    // registers
    reg [1:0] ctrl_q;
    reg [`QSR_EV_W-1:0] ist_q;
    reg [`QSR_EV_W-1:0] ist_d;
    reg [`QSR_EV_W-1:0] imask_q;
    reg [DROP_W-1:0] drop_cnt_q;

    // hold stage between event capture and output
    reg s1_vld_q;
    reg s1_first_q;
    reg s1_is_err_q;
    reg [1:0] s1_kind_q;
    reg [1:0] s1_fault_q;
    reg s1_irq_q;
    reg [`QSR_COOKIE_W-1:0] s1_cookie_q;
    reg [QID_W-1:0] s1_qid_q;
    reg [PORT_W-1:0] s1_port_q;
    reg s1_retry_q;
    reg hit_set_q;
    reg hit_clr_q;

    wire en = ctrl_q[`QSR_CTRL_ENABLE_BIT];
    wire err_want = I_ERR_VLD & en & ctrl_q[`QSR_CTRL_ERR_EN_BIT];
    wire mrk_want = I_MRK_VLD & en;
    wire flag_rd;

    // transfer completes when valid and ready meet
    wire out_free = ~O_STS_VLD | I_STS_RDY;
    wire s1_move = s1_vld_q & out_free;
    wire s1_free = ~s1_vld_q | s1_move;
    // errors take precedence over markers in the same cycle
    wire cap_err = err_want & s1_free;
    wire cap_mrk = mrk_want & ~err_want & s1_free;
    wire cap = cap_err | cap_mrk;
    wire drop = (err_want & mrk_want) | ((err_want | mrk_want) & ~s1_free);
    wire [QID_W-1:0] rd_qid = err_want ? I_ERR_QID : I_MRK_QID;

    // outstanding flag of the held queue, corrected for writes in flight
    wire clr_now = I_IRQ_DONE_VLD & (I_IRQ_DONE_QID == s1_qid_q);
    wire outstanding = (hit_set_q | (flag_rd & ~hit_clr_q)) & ~clr_now;
    wire retry_now = s1_irq_q & ~s1_is_err_q & outstanding;
    wire s1_retry = s1_first_q ? retry_now : s1_retry_q;
    // the interrupt fires when wanted and none is outstanding
    wire set_we = s1_first_q & s1_vld_q & s1_irq_q & ~s1_is_err_q & ~outstanding;

    qsr_flag_mem #(
        .DEPTH(QUEUES),
        .AW(QID_W)
    ) u_flags (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_rd_idx(rd_qid),
        .o_rd_data(flag_rd),
        .i_set_we(set_we),
        .i_set_idx(s1_qid_q),
        .i_clr_we(I_IRQ_DONE_VLD),
        .i_clr_idx(I_IRQ_DONE_QID)
    );

    // capture one event into the hold stage
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            s1_vld_q <= 1'b0;
            s1_first_q <= 1'b0;
            s1_is_err_q <= 1'b0;
            s1_kind_q <= 2'h0;
            s1_fault_q <= 2'h0;
            s1_irq_q <= 1'b0;
            s1_cookie_q <= {`QSR_COOKIE_W{1'b0}};
            s1_qid_q <= {QID_W{1'b0}};
            s1_port_q <= {PORT_W{1'b0}};
            s1_retry_q <= 1'b0;
            hit_set_q <= 1'b0;
            hit_clr_q <= 1'b0;
        end else begin
            s1_first_q <= cap;
            if (s1_first_q) begin
                s1_retry_q <= retry_now;
            end
            hit_set_q <= set_we & (s1_qid_q == rd_qid);
            hit_clr_q <= I_IRQ_DONE_VLD & (I_IRQ_DONE_QID == rd_qid);
            if (cap) begin
                s1_vld_q <= 1'b1;
                s1_is_err_q <= cap_err;
                s1_qid_q <= rd_qid;
                if (cap_err) begin
                    s1_kind_q <= 2'h0;
                    s1_fault_q <= I_ERR_FAULT;
                    s1_irq_q <= 1'b0;
                    s1_cookie_q <= {`QSR_COOKIE_W{1'b0}};
                    s1_port_q <= I_ERR_PORT;
                end else begin
                    s1_kind_q <= I_MRK_KIND;
                    s1_fault_q <= I_MRK_FAULT;
                    s1_irq_q <= I_MRK_IRQ_WANT;
                    // only the low bits, stamped bits above stay out
                    s1_cookie_q <= I_MRK_ENTRY[`QSR_COOKIE_W-1:0];
                    s1_port_q <= I_MRK_PORT;
                end
            end else if (s1_move) begin
                s1_vld_q <= 1'b0;
            end
        end
    end

    // output register, held while valid is high and ready is low
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_STS_VLD <= 1'b0;
            O_STS_OPCODE <= `QSR_OP_COMPLETION;
            O_STS_DATA <= 64'h0;
            O_STS_PORT_IDENT <= {PORT_W{1'b0}};
            O_STS_QID <= {QID_W{1'b0}};
        end else if (out_free) begin
            O_STS_VLD <= s1_vld_q;
            if (s1_vld_q) begin
                // kind 0..3 only, upper opcode bits zero
                O_STS_OPCODE <= {6'h00, s1_kind_q};
                // fault, retry, cookie, origin flag
                O_STS_DATA <= build_word(s1_fault_q, s1_retry, s1_cookie_q,
                    ~s1_is_err_q);
                O_STS_PORT_IDENT <= s1_port_q;
                O_STS_QID <= s1_qid_q;
            end
        end
    end

    // interrupt status events, set wins over clear
    always @* begin
        ist_d = ist_q;
        if (I_WR && (I_ADDR == `QSR_REG_IRQ_STATUS)) begin
            ist_d = ist_d & ~I_WDATA[`QSR_EV_W-1:0];
        end
        if (s1_move && !s1_is_err_q) begin
            ist_d[`QSR_EV_MARKER] = 1'b1;
        end
        if (s1_move && s1_is_err_q) begin
            ist_d[`QSR_EV_ERROR] = 1'b1;
        end
        if (s1_move && s1_retry) begin
            ist_d[`QSR_EV_RETRY] = 1'b1;
        end
        if (drop) begin
            ist_d[`QSR_EV_DROP] = 1'b1;
        end
    end

    // control, mask, status, drop counter
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_q <= `QSR_CTRL_RESET;
            imask_q <= {`QSR_EV_W{1'b0}};
            ist_q <= {`QSR_EV_W{1'b0}};
            drop_cnt_q <= {DROP_W{1'b0}};
            O_IRQ <= 1'b0;
        end else begin
            ist_q <= ist_d;
            O_IRQ <= |(ist_d & imask_q);
            if (drop && (drop_cnt_q != {DROP_W{1'b1}})) begin
                drop_cnt_q <= drop_cnt_q + {{(DROP_W-1){1'b0}}, 1'b1};
            end
            if (I_WR && (I_ADDR == `QSR_REG_CTRL)) begin
                ctrl_q <= I_WDATA[1:0];
            end
            if (I_WR && (I_ADDR == `QSR_REG_IRQ_MASK)) begin
                imask_q <= I_WDATA[`QSR_EV_W-1:0];
            end
        end
    end

    // read data, valid only in the cycle after the strobe
    always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 32'h0;
        end else if (I_RD) begin
            case (I_ADDR)
                `QSR_REG_CTRL: begin
                    O_RDATA <= {30'h0, ctrl_q};
                end
                `QSR_REG_IRQ_STATUS: begin
                    O_RDATA <= {28'h0, ist_q};
                end
                `QSR_REG_IRQ_MASK: begin
                    O_RDATA <= {28'h0, imask_q};
                end
                `QSR_REG_STATE: begin
                    O_RDATA <= {drop_cnt_q, 14'h0, s1_vld_q, O_STS_VLD};
                end
                `QSR_REG_LAST: begin
                    O_RDATA <= {O_STS_OPCODE, 1'b0, O_STS_PORT_IDENT, 8'h0, O_STS_QID};
                end
                default: begin
                    O_RDATA <= 32'h0;
                end
            endcase
        end else begin
            O_RDATA <= 32'h0;
        end
    end

endmodule

// *** tb/qsr_asserts.sv ***
// checker of the status output against its causes
`timescale 1ns/1ps
module qsr_asserts #(
    parameter QID_W = 12,
    parameter PORT_W = 3,
    parameter ENTRY_W = 32
) (
    input wire I_CORE_CLK, // clock
    input wire I_RST, // reset
    input wire I_MRK_VLD, // marker event
    input wire [1:0] I_MRK_KIND, // kind
    input wire [1:0] I_MRK_FAULT, // fault
    input wire I_MRK_IRQ_WANT, // irq wanted
    input wire [ENTRY_W-1:0] I_MRK_ENTRY, // entry
    input wire [QID_W-1:0] I_MRK_QID, // queue
    input wire [PORT_W-1:0] I_MRK_PORT, // port
    input wire I_ERR_VLD, // error event
    input wire [1:0] I_ERR_FAULT, // fault
    input wire O_STS_VLD, // valid
    input wire [7:0] O_STS_OPCODE, // opcode
    input wire [63:0] O_STS_DATA, // word
    input wire [PORT_W-1:0] O_STS_PORT_IDENT, // port
    input wire [QID_W-1:0] O_STS_QID, // queue
    input wire I_STS_RDY // ready
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);
    // marker taken, no error beside it
    wire mrk_in = I_MRK_VLD && !I_ERR_VLD;
    // output relations, two edges after capture
    chk_opcode_range: assert property (O_STS_VLD |-> O_STS_OPCODE < 8'h04)
        else $error("opcode out of range");
    chk_rsvd_zero: assert property (O_STS_VLD |-> O_STS_DATA[63:27] == 37'h0)
        else $error("reserved bits set");
    chk_vld_cause: assert property ($rose(O_STS_VLD) |-> $past(I_MRK_VLD || I_ERR_VLD, 2))
        else $error("valid without event");
    chk_mrk_fields: assert property ($past(mrk_in, 2) && O_STS_VLD |-> O_STS_DATA[26]
        && O_STS_OPCODE == {6'h00, $past(I_MRK_KIND, 2)} && O_STS_QID == $past(I_MRK_QID, 2)
        && O_STS_PORT_IDENT == $past(I_MRK_PORT, 2)) else $error("marker fields wrong");
    chk_mrk_cookie: assert property ($past(mrk_in, 2) && O_STS_VLD |->
        O_STS_DATA[25:3] == $past(I_MRK_ENTRY[22:0], 2)) else $error("cookie wrong");
    chk_mrk_fault: assert property ($past(mrk_in, 2) && O_STS_VLD |->
        O_STS_DATA[1:0] == $past(I_MRK_FAULT, 2)) else $error("marker fault wrong");
    chk_no_retry: assert property ($past(mrk_in && !I_MRK_IRQ_WANT, 2) && O_STS_VLD |->
        !O_STS_DATA[2]) else $error("retry without request");
    chk_err_fields: assert property ($past(I_ERR_VLD, 2) && O_STS_VLD |->
        !O_STS_DATA[26] && !O_STS_DATA[2] && O_STS_DATA[1:0] == $past(I_ERR_FAULT, 2))
        else $error("error fields wrong");
    chk_stall_hold: assert property (O_STS_VLD && !I_STS_RDY |=> O_STS_VLD
        && $stable(O_STS_DATA) && $stable(O_STS_QID)) else $error("stalled output moved");
endmodule

bind qsr_top qsr_asserts #(.QID_W(QID_W), .PORT_W(PORT_W), .ENTRY_W(ENTRY_W)) u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_MRK_VLD(I_MRK_VLD), .I_MRK_KIND(I_MRK_KIND),
    .I_MRK_FAULT(I_MRK_FAULT), .I_MRK_IRQ_WANT(I_MRK_IRQ_WANT), .I_MRK_ENTRY(I_MRK_ENTRY),
    .I_MRK_QID(I_MRK_QID), .I_MRK_PORT(I_MRK_PORT), .I_ERR_VLD(I_ERR_VLD),
    .I_ERR_FAULT(I_ERR_FAULT), .O_STS_VLD(O_STS_VLD), .O_STS_OPCODE(O_STS_OPCODE),
    .O_STS_DATA(O_STS_DATA), .O_STS_PORT_IDENT(O_STS_PORT_IDENT), .O_STS_QID(O_STS_QID),
    .I_STS_RDY(I_STS_RDY));

// *** tb/qsr_user_model.sv ***
// user logic model: takes status transfers, keeps the last cookie
`timescale 1ns/1ps
module qsr_user_model (
    input wire i_clk, // clock
    input wire i_rst, // reset
    input wire i_vld, // status valid
    input wire [63:0] i_data, // status word
    input wire i_stall, // stall ordered by a scenario
    output wire o_rdy, // status ready
    output reg [22:0] o_cookie_q // last user cookie
);
    // ready held high unless a scenario stalls
    assign o_rdy = !i_stall;
    // cookie kept from user markers only, upper bits unused
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cookie_q <= 23'h0;
        end else if (i_vld && o_rdy && i_data[26]) begin
            o_cookie_q <= i_data[25:3];
        end
    end
endmodule

// *** tb/queue_status_report_port_bench.sv ***
// self-checking bench of the queue status report port
`timescale 1ns/1ps
module queue_status_report_port_bench;
    typedef struct packed {
        logic e;
        logic [1:0] k;
        logic [1:0] f;
        logic w;
        logic r;
        logic [31:0] n;
        logic [11:0] q;
        logic [2:0] p;
    } qsr_row_t;
    reg clk = 1'b0, rst = 1'b1, mv = 1'b0, mw = 1'b0, ev = 1'b0, dv = 1'b0;
    reg wr = 1'b0, rd = 1'b0, stall = 1'b0;
    reg [1:0] mk = 2'h0, mf = 2'h0, ef = 2'h0;
    reg [31:0] ent = 32'h0, wd = 32'h0;
    reg [11:0] mq = 12'h0, eq = 12'h0, dq = 12'h0;
    reg [2:0] mp = 3'h0, ep = 3'h0;
    reg [7:0] addr = 8'h0;
    wire vld, rdy, irq;
    wire [7:0] op;
    wire [63:0] data;
    wire [2:0] port;
    wire [11:0] qid;
    wire [31:0] rdata;
    wire [22:0] cookie;
    integer miscompares = 0, cmp_count = 0, i;
    // error, kind, fault, want, retry, entry, queue, port
    qsr_row_t rows [0:5] = '{
        '{1'b0, 2'h0, 2'h0, 1'b1, 1'b0, 32'hffffffff, 12'h001, 3'h1},
        '{1'b0, 2'h1, 2'h1, 1'b1, 1'b1, 32'h00400001, 12'h001, 3'h2},
        '{1'b0, 2'h2, 2'h2, 1'b0, 1'b0, 32'h007fffff, 12'h002, 3'h7},
        '{1'b0, 2'h3, 2'h3, 1'b1, 1'b0, 32'h12345678, 12'hfff, 3'h0},
        '{1'b1, 2'h0, 2'h1, 1'b0, 1'b0, 32'h00000000, 12'h003, 3'h4},
        '{1'b1, 2'h0, 2'h3, 1'b0, 1'b0, 32'h00000000, 12'h000, 3'h5}};
    qsr_top DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_MRK_VLD(mv), .I_MRK_KIND(mk),
        .I_MRK_FAULT(mf), .I_MRK_IRQ_WANT(mw), .I_MRK_ENTRY(ent), .I_MRK_QID(mq),
        .I_MRK_PORT(mp), .I_ERR_VLD(ev), .I_ERR_FAULT(ef), .I_ERR_QID(eq), .I_ERR_PORT(ep),
        .I_IRQ_DONE_VLD(dv), .I_IRQ_DONE_QID(dq), .O_STS_VLD(vld), .O_STS_OPCODE(op),
        .O_STS_DATA(data), .O_STS_PORT_IDENT(port), .O_STS_QID(qid), .I_STS_RDY(rdy),
        .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq));
    qsr_user_model u_user (.i_clk(clk), .i_rst(rst), .i_vld(vld), .i_data(data),
        .i_stall(stall), .o_rdy(rdy), .o_cookie_q(cookie));
    // 20 MHz clock
    always #25 clk = ~clk;
    // counted comparison
    task cmp(input logic [63:0] got, input logic [63:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            miscompares = miscompares + 1;
        end
    endtask
    // one event, returns just after its output edge
    task send(input qsr_row_t r);
        @(posedge clk);
        if (r.e) begin
            ev <= 1'b1;
            ef <= r.f;
            eq <= r.q;
            ep <= r.p;
        end else begin
            mv <= 1'b1;
            {mk, mf, mw, ent, mq, mp} <= {r.k, r.f, r.w, r.n, r.q, r.p};
        end
        @(posedge clk);
        mv <= 1'b0;
        ev <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // register write and checked read
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wd} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp({32'h0, rdata}, {32'h0, exp});
    endtask
    task end_sim;
        $display("mismatches %0d, comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog far beyond the roughly 80 cycles needed
    initial begin
        repeat (3000) @(posedge clk);
        miscompares = miscompares + 1;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h00, 32'h3);
        for (i = 0; i < 6; i = i + 1) begin
            send(rows[i]);
            cmp({63'h0, vld}, 64'h1); // valid raised
            cmp({56'h0, op}, rows[i].e ? 64'h0 : {62'h0, rows[i].k}); // opcode
            cmp(data, {37'h0, !rows[i].e, rows[i].e ? 23'h0 : rows[i].n[22:0], rows[i].r,
                rows[i].f}); // word
            cmp({49'h0, port, qid}, {49'h0, rows[i].p, rows[i].q}); // idents
        end
        cmp({41'h0, cookie}, {41'h0, rows[3].n[22:0]}); // error cookie ignored
        // status: marker, error and retry seen; clear and mask
        rd_reg(8'h04, 32'h7);
        wr_reg(8'h04, 32'hf);
        rd_reg(8'h04, 32'h0);
        wr_reg(8'h08, 32'h1);
        rd_reg(8'h20, 32'h0);
        // interrupt done on queue 1, then marker reissued
        @(posedge clk);
        {dv, dq} <= {1'b1, 12'h001};
        @(posedge clk);
        dv <= 1'b0;
        send(rows[0]);
        cmp({63'h0, data[2]}, 64'h0); // reissue succeeds
        cmp({63'h0, irq}, 64'h1);
        wr_reg(8'h04, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        cmp({63'h0, irq}, 64'h0);
        // stalled output holds its valid and queue
        @(posedge clk);
        stall <= 1'b1;
        send(rows[2]);
        repeat (3) @(posedge clk);
        #1;
        cmp({51'h0, vld, qid}, {51'h0, 1'b1, 12'h002}); // held
        @(posedge clk);
        stall <= 1'b0;
        @(posedge clk);
        #1;
        cmp({63'h0, vld}, 64'h0);
        // disabled port reports nothing
        wr_reg(8'h00, 32'h0);
        send(rows[3]);
        cmp({63'h0, vld}, 64'h0);
        wr_reg(8'h00, 32'h3);
        // last output fields and idle state, no drops
        rd_reg(8'h10, 32'h02700002);
        rd_reg(8'h0c, 32'h0);
        end_sim;
    end
endmodule
